// *** rtl/i2c_defs.vh ***
// register map, field positions, reset values and divider constants
`ifndef I2C_DEFS_VH
`define I2C_DEFS_VH

`define ADDR_STATUS_ONE   8'h00
`define ADDR_STATUS_TWO   8'h04
`define ADDR_TX_DATA      8'h08
`define ADDR_RX_DATA      8'h0C
`define ADDR_CONTROL      8'h10
`define ADDR_CLOCK_CTRL   8'h14
`define ADDR_IRQ_MASK     8'h18

`define CR_PE             5
`define CR_GCE            4
`define CR_START          3
`define CR_ACK            2
`define CR_STOP           1
`define CR_ITE            0
`define CCR_FM            7

`define CONTROL_RESET     8'h00
`define CLOCK_CTRL_RESET  8'h00
`define IRQ_MASK_RESET    1'b0
`define TX_DATA_RESET     8'h00

`define STD_MUL           9'h003
`define STD_ADD           9'h00B
`define FAST_MUL          9'h002
`define FAST_ADD          9'h009

`define HEADER_PATTERN    5'h1E
`define GENERAL_CALL      8'h00

`endif

// *** rtl/i2c_line_monitor.v ***
// pin synchronisers and start/stop/busy detection for the two bus lines
`timescale 1ns/1ps
module i2c_line_monitor (
  input  wire clock,
  input  wire reset,
  input  wire sclIn,
  input  wire sdaIn,
  output wire sclLevel,
  output wire sdaLevel,
  output wire startSeen,
  output wire stopSeen,
  output wire busy
);
  reg [2:0] sclSync_ff;
  reg [2:0] sdaSync_ff;
  reg       sclLvl_ff;
  reg       sdaLvl_ff;
  reg       start_ff;
  reg       stop_ff;
  reg       busy_ff;
  wire      nxt_scl;
  wire      nxt_sda;

  // a change counts once the last two stages agree
  assign nxt_scl = (sclSync_ff[1] == sclSync_ff[2]) ? sclSync_ff[2] : sclLvl_ff;
  assign nxt_sda = (sdaSync_ff[1] == sdaSync_ff[2]) ? sdaSync_ff[2] : sdaLvl_ff;

  always @(posedge clock) begin
    if (reset) begin
      sclSync_ff <= 3'h7;
      sdaSync_ff <= 3'h7;
      sclLvl_ff  <= 1'b1;
      sdaLvl_ff  <= 1'b1;
      start_ff   <= 1'b0;
      stop_ff    <= 1'b0;
      busy_ff    <= 1'b0;
    end else begin
      sclSync_ff <= {sclSync_ff[1:0], sclIn};
      sdaSync_ff <= {sdaSync_ff[1:0], sdaIn};
      sclLvl_ff  <= nxt_scl;
      sdaLvl_ff  <= nxt_sda;
      start_ff   <= sclLvl_ff & nxt_scl & sdaLvl_ff & ~nxt_sda;
      stop_ff    <= sclLvl_ff & nxt_scl & ~sdaLvl_ff & nxt_sda;
      if (sclLvl_ff & nxt_scl & sdaLvl_ff & ~nxt_sda)
        busy_ff <= 1'b1;
      else if (sclLvl_ff & nxt_scl & ~sdaLvl_ff & nxt_sda)
        busy_ff <= 1'b0;
    end
  end

  assign sclLevel  = sclLvl_ff;
  assign sdaLevel  = sdaLvl_ff;
  assign startSeen = start_ff;
  assign stopSeen  = stop_ff;
  assign busy      = busy_ff;
endmodule // i2c_line_monitor

// *** rtl/i2c_master_event_control.v ***
// two-wire bus master with event flags, control register and apb slave
//
// How it works
// RULE1: slave: stop toggle with byte-done releases lines
// RULE2: start while bus idle enters master, starts
// RULE3: start sent flags event, holds clock
// RULE4: 10-bit header sets flag, waits second byte
// RULE5: address done flags event, waits control write
// RULE6: software repeats start for 10-bit read
// RULE7: receive: ack, flag, hold until reads
// RULE8: stop before last read ends receive
// RULE9: software clears ack before second-last read
// RULE10: transmit: hold until write, flag on ack
// RULE11: stop after last write ends transmit
// RULE12: start/stop mid-byte sets bus error
// RULE13: nack sets flag; start or stop resumes
// RULE14: arbitration loss flags, drops to slave
// RULE15: no clock stretch after errors
// RULE16: nack and byte-done cleared separately
// RULE17: one interrupt gated by enable and mask
// RULE18: disabled clears bits except stop, releases pins
// RULE19: first enabling write only sets enable
// RULE20: general call enable, cleared when disabled
// RULE21: start bit cleared when start sent
// RULE22: stop bit produces stop, then cleared
`timescale 1ns/1ps
`include "i2c_defs.vh"
module i2c_master_event_control (
  input  wire        clock,
  input  wire        reset,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        sclIn,
  output wire        sclOut,
  output wire        sclOe,
  input  wire        sdaIn,
  output wire        sdaOut,
  output wire        sdaOe,
  output wire        irq,
  output wire        wakeRequest,
  output wire        generalCallMatch
);
  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_STA0 = 4'h1;
  localparam [3:0] ST_STA1 = 4'h2;
  localparam [3:0] ST_STA2 = 4'h3;
  localparam [3:0] ST_WAIT = 4'h4;
  localparam [3:0] ST_XFER = 4'h5;
  localparam [3:0] ST_STP1 = 4'h6;
  localparam [3:0] ST_STP2 = 4'h7;
  localparam [3:0] ST_STP3 = 4'h8;
  localparam [3:0] ST_HOLD = 4'h9;

  localparam [2:0] W_ADDR   = 3'h0;
  localparam [2:0] W_SECOND = 3'h1;
  localparam [2:0] W_CR     = 3'h2;
  localparam [2:0] W_TXD    = 3'h3;
  localparam [2:0] W_RXD    = 3'h4;

  localparam [1:0] R_HDR  = 2'h0;
  localparam [1:0] R_ADR  = 2'h1;
  localparam [1:0] R_DATA = 2'h2;

  localparam [7:0] CR_RST  = `CONTROL_RESET;
  localparam [7:0] CCR_RST = `CLOCK_CTRL_RESET;

  reg        pe_ff, gce_ff, start_ff, ack_ff, stop_ff, ite_ff;
  reg        fm_ff;
  reg [6:0]  cc_ff;
  reg        mask_ff;
  reg [7:0]  txData_ff;
  reg [7:0]  rxData_ff;
  reg [7:0]  shift_ff;
  reg        event_ff, header_ff, tra_ff, btf_ff, master_ff, sb_ff;
  reg        nack_ff, stopSeen_ff, arb_ff, bus_error_flag_ff;
  reg [3:0]  state_ff;
  reg [2:0]  kind_ff;
  reg [1:0]  role_ff;
  reg        phase_ff;
  reg [3:0]  bitCnt_ff;
  reg        txMode_ff;
  reg        readDir_ff;
  reg        sr1Seen_ff;
  reg        stopPrev_ff;
  reg        suppress_ff;
  reg        sclDrive_ff;
  reg        sdaDrive_ff;
  reg        gcMatch_ff;
  reg [7:0]  divCnt_ff;
  reg [31:0] prdata_ff;
  reg        irq_ff;
  reg [31:0] readMux;

  wire       sclLevel, sdaLevel, startPulse, stopPulse, busy;
  wire       access = psel & penable;
  wire       wrEn   = access & pwrite;
  wire       rdEn   = access & ~pwrite;
  wire       wrTx   = wrEn & (paddr == `ADDR_TX_DATA);
  wire       wrCr   = wrEn & (paddr == `ADDR_CONTROL);
  wire       wrCcr  = wrEn & (paddr == `ADDR_CLOCK_CTRL);
  wire       wrMask = wrEn & (paddr == `ADDR_IRQ_MASK);
  wire       rdSr1  = rdEn & (paddr == `ADDR_STATUS_ONE);
  wire       rdSr2  = rdEn & (paddr == `ADDR_STATUS_TWO);
  wire       rdRx   = rdEn & (paddr == `ADDR_RX_DATA);
  wire [7:0] half;
  wire       tick;
  wire [7:0] statusOne;
  wire [7:0] statusTwo;

  function isMapped;
    input [7:0] a;
    begin
      isMapped = (a == `ADDR_STATUS_ONE) | (a == `ADDR_STATUS_TWO) |
                 (a == `ADDR_TX_DATA) | (a == `ADDR_RX_DATA) |
                 (a == `ADDR_CONTROL) | (a == `ADDR_CLOCK_CTRL) |
                 (a == `ADDR_IRQ_MASK);
    end
  endfunction

  // half of the bus clock period in system clocks
  function [7:0] halfPeriod;
    input       standard;
    input [6:0] cc;
    reg   [8:0] p;
    begin
      p = standard ? (`STD_MUL * {2'b00, cc} + `STD_ADD)
                   : (`FAST_MUL * {2'b00, cc} + `FAST_ADD);
      halfPeriod = p[8:1];
    end
  endfunction

  i2c_line_monitor lineMonitor (
    .clock     (clock),
    .reset     (reset),
    .sclIn     (sclIn),
    .sdaIn     (sdaIn),
    .sclLevel  (sclLevel),
    .sdaLevel  (sdaLevel),
    .startSeen (startPulse),
    .stopSeen  (stopPulse),
    .busy      (busy)
  );

  assign half = halfPeriod(fm_ff, cc_ff);
  assign tick = (divCnt_ff >= half);

  assign statusOne = {event_ff, header_ff, tra_ff, busy, btf_ff, 1'b0, master_ff, sb_ff};
  assign statusTwo = {3'h0, nack_ff, stopSeen_ff, arb_ff, bus_error_flag_ff, 1'b0};

  always @* begin
    readMux = 32'h0000_0000;
    case (paddr)
      `ADDR_STATUS_ONE: readMux = {24'h000000, statusOne};
      `ADDR_STATUS_TWO: readMux = {24'h000000, statusTwo};
      `ADDR_TX_DATA:    readMux = {24'h000000, txData_ff};
      `ADDR_RX_DATA:    readMux = {24'h000000, rxData_ff};
      `ADDR_CONTROL:    readMux = {26'h0000000, pe_ff, gce_ff, start_ff, ack_ff, stop_ff, ite_ff};
      `ADDR_CLOCK_CTRL: readMux = {24'h000000, fm_ff, cc_ff};
      `ADDR_IRQ_MASK:   readMux = {31'h00000000, mask_ff};
      default:          readMux = 32'h0000_0000;
    endcase
  end

  // read data captured in setup so the access phase shows a stable word
  always @(posedge clock) begin
    if (reset) begin
      prdata_ff <= 32'h0000_0000;
      fm_ff     <= CCR_RST[`CCR_FM];
      cc_ff     <= CCR_RST[6:0];
      mask_ff   <= `IRQ_MASK_RESET;
      txData_ff <= `TX_DATA_RESET;
      divCnt_ff <= 8'h00;
      irq_ff    <= 1'b0;
    end else begin
      if (psel & ~penable)
        prdata_ff <= readMux;
      if (wrCcr) begin
        fm_ff <= pwdata[`CCR_FM];
        cc_ff <= pwdata[6:0];
      end
      if (wrMask)
        mask_ff <= pwdata[0];
      if (wrTx)
        txData_ff <= pwdata[7:0];
      divCnt_ff <= tick ? 8'h00 : divCnt_ff + 8'h01;
      // RULE17: one line, enable and mask
      irq_ff <= event_ff & ite_ff & mask_ff;
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      {pe_ff, gce_ff, start_ff, ack_ff, stop_ff, ite_ff} <= CR_RST[5:0];
      {event_ff, header_ff, tra_ff, btf_ff, master_ff, sb_ff} <= 6'h00;
      {nack_ff, stopSeen_ff, arb_ff, bus_error_flag_ff} <= 4'h0;
      state_ff    <= ST_IDLE;
      kind_ff     <= W_ADDR;
      role_ff     <= R_HDR;
      phase_ff    <= 1'b0;
      bitCnt_ff   <= 4'h0;
      txMode_ff   <= 1'b0;
      readDir_ff  <= 1'b0;
      sr1Seen_ff  <= 1'b0;
      stopPrev_ff <= 1'b0;
      suppress_ff <= 1'b0;
      sclDrive_ff <= 1'b0;
      sdaDrive_ff <= 1'b0;
      shift_ff    <= 8'h00;
      rxData_ff   <= 8'h00;
      gcMatch_ff  <= 1'b0;
    end else if (!pe_ff) begin
      // RULE18: all but stop cleared, pins released
      {gce_ff, start_ff, ack_ff, ite_ff} <= 4'h0;
      {event_ff, header_ff, tra_ff, btf_ff, master_ff, sb_ff} <= 6'h00;
      {nack_ff, stopSeen_ff, arb_ff, bus_error_flag_ff} <= 4'h0;
      state_ff    <= ST_IDLE;
      sr1Seen_ff  <= 1'b0;
      sclDrive_ff <= 1'b0;
      sdaDrive_ff <= 1'b0;
      gcMatch_ff  <= 1'b0;
      stopPrev_ff <= stop_ff;
      // RULE19: first write only enables
      if (wrCr)
        pe_ff <= pwdata[`CR_PE];
    end else begin
      stopPrev_ff <= stop_ff;
      if (wrCr) begin
        pe_ff    <= pwdata[`CR_PE];
        // RULE20: general call enable bit
        gce_ff   <= pwdata[`CR_GCE];
        start_ff <= pwdata[`CR_START];
        ack_ff   <= pwdata[`CR_ACK];
        stop_ff  <= pwdata[`CR_STOP];
        ite_ff   <= pwdata[`CR_ITE];
      end
      // RULE20: only 00h counts as general call
      gcMatch_ff <= gce_ff & (rxData_ff == `GENERAL_CALL) & ~master_ff;
      // RULE16: status two read clears error flags
      if (rdSr2) begin
        {nack_ff, stopSeen_ff, arb_ff, bus_error_flag_ff} <= 4'h0;
        if (nack_ff | stopSeen_ff | arb_ff | bus_error_flag_ff)
          event_ff <= 1'b0;
      end
      if (rdSr1)
        sr1Seen_ff <= 1'b1;
      // RULE1: stop toggle releases lines in slave mode
      if (!master_ff && stopPrev_ff && !stop_ff && btf_ff) begin
        btf_ff      <= 1'b0;
        tra_ff      <= 1'b0;
        event_ff    <= 1'b0;
        suppress_ff <= 1'b1;
        sclDrive_ff <= 1'b0;
        sdaDrive_ff <= 1'b0;
      end
      // RULE16: any byte after status read clears byte-done
      if (!master_ff && sr1Seen_ff && wrTx && btf_ff) begin
        btf_ff     <= 1'b0;
        tra_ff     <= 1'b0;
        event_ff   <= 1'b0;
        sr1Seen_ff <= 1'b0;
      end
      // own or released stop is not reported
      if (stopPulse && !master_ff) begin
        if (suppress_ff)
          suppress_ff <= 1'b0;
        else if (state_ff == ST_IDLE && busy) begin
          stopSeen_ff <= 1'b1;
          event_ff    <= 1'b1;
        end
      end
      case (state_ff)
        ST_IDLE: begin
          sclDrive_ff <= 1'b0;
          sdaDrive_ff <= 1'b0;
          // RULE2: start when the bus is free
          if (start_ff && !busy) begin
            master_ff <= 1'b1;
            state_ff  <= ST_STA1;
          end
        end
        ST_STA0: begin
          sdaDrive_ff <= 1'b0;
          if (tick) begin
            sclDrive_ff <= 1'b0;
            state_ff    <= ST_STA1;
          end
        end
        ST_STA1: begin
          if (tick && sclLevel) begin
            sdaDrive_ff <= 1'b1;
            state_ff    <= ST_STA2;
          end
        end
        ST_STA2: begin
          if (tick) begin
            sclDrive_ff <= 1'b1;
            // RULE21: start bit cleared once sent
            start_ff    <= 1'b0;
            // RULE3: start sent, hold clock low
            sb_ff       <= 1'b1;
            event_ff    <= 1'b1;
            sr1Seen_ff  <= 1'b0;
            kind_ff     <= W_ADDR;
            state_ff    <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          sclDrive_ff <= 1'b1;
          if (stop_ff) begin
            // RULE22: stop after byte or start
            // RULE8: stop ends receive, data kept
            // RULE11: stop ends transmit
            sdaDrive_ff <= 1'b1;
            state_ff    <= ST_STP1;
          end else if (start_ff) begin
            // RULE6: repeated start on request
            state_ff <= ST_STA0;
          end else begin
            case (kind_ff)
              W_ADDR, W_SECOND, W_TXD: begin
                // RULE10: load byte after status read and write
                if (sr1Seen_ff && wrTx) begin
                  shift_ff   <= pwdata[7:0];
                  txMode_ff  <= 1'b1;
                  phase_ff   <= 1'b0;
                  bitCnt_ff  <= 4'h0;
                  sb_ff      <= 1'b0;
                  header_ff  <= 1'b0;
                  btf_ff     <= 1'b0;
                  tra_ff     <= 1'b0;
                  event_ff   <= 1'b0;
                  sr1Seen_ff <= 1'b0;
                  state_ff   <= ST_XFER;
                  if (kind_ff == W_TXD)
                    role_ff <= R_DATA;
                  else if (kind_ff == W_SECOND) begin
                    role_ff    <= R_ADR;
                    readDir_ff <= 1'b0;
                  end else if (pwdata[7:3] == `HEADER_PATTERN && !pwdata[0])
                    // RULE4: 10-bit header takes a second byte
                    role_ff <= R_HDR;
                  else begin
                    role_ff    <= R_ADR;
                    readDir_ff <= pwdata[0];
                  end
                end
              end
              W_CR: begin
                // RULE5: status read then control write
                if (sr1Seen_ff && wrCr) begin
                  event_ff   <= 1'b0;
                  sr1Seen_ff <= 1'b0;
                  if (readDir_ff) begin
                    txMode_ff <= 1'b0;
                    role_ff   <= R_DATA;
                    phase_ff  <= 1'b0;
                    bitCnt_ff <= 4'h0;
                    state_ff  <= ST_XFER;
                  end else
                    kind_ff <= W_TXD;
                end
              end
              W_RXD: begin
                // RULE7: status read then data read
                if (sr1Seen_ff && rdRx) begin
                  btf_ff     <= 1'b0;
                  event_ff   <= 1'b0;
                  sr1Seen_ff <= 1'b0;
                  phase_ff   <= 1'b0;
                  bitCnt_ff  <= 4'h0;
                  state_ff   <= ST_XFER;
                end
              end
              default: kind_ff <= W_ADDR;
            endcase
          end
        end
        ST_XFER: begin
          if (!phase_ff) begin
            sclDrive_ff <= 1'b1;
            if (tick) begin
              phase_ff <= 1'b1;
              if (bitCnt_ff < 4'h8)
                sdaDrive_ff <= txMode_ff & ~shift_ff[7];
              else
                // RULE7: ack pulse only when enabled
                // RULE9: cleared ack gives a nack
                sdaDrive_ff <= ~txMode_ff & ack_ff;
            end
          end else begin
            sclDrive_ff <= 1'b0;
            if (tick && sclLevel) begin
              phase_ff    <= 1'b0;
              sclDrive_ff <= 1'b1;
              if (bitCnt_ff < 4'h8) begin
                shift_ff  <= {shift_ff[6:0], sdaLevel};
                bitCnt_ff <= bitCnt_ff + 4'h1;
                // RULE14: lost arbitration, back to slave
                if (txMode_ff && shift_ff[7] && !sdaLevel) begin
                  arb_ff      <= 1'b1;
                  event_ff    <= 1'b1;
                  master_ff   <= 1'b0;
                  sclDrive_ff <= 1'b0;
                  sdaDrive_ff <= 1'b0;
                  state_ff    <= ST_IDLE;
                end
              end else begin
                bitCnt_ff  <= 4'h0;
                sr1Seen_ff <= 1'b0;
                state_ff   <= ST_WAIT;
                if (txMode_ff && sdaLevel) begin
                  // RULE13: nack flags, waits start or stop
                  // RULE15: clock released after nack
                  nack_ff     <= 1'b1;
                  event_ff    <= 1'b1;
                  sclDrive_ff <= 1'b0;
                  state_ff    <= ST_HOLD;
                end else if (!txMode_ff) begin
                  rxData_ff <= shift_ff;
                  btf_ff    <= 1'b1;
                  tra_ff    <= 1'b0;
                  event_ff  <= 1'b1;
                  kind_ff   <= W_RXD;
                end else if (role_ff == R_HDR) begin
                  header_ff <= 1'b1;
                  event_ff  <= 1'b1;
                  kind_ff   <= W_SECOND;
                end else if (role_ff == R_ADR) begin
                  event_ff <= 1'b1;
                  kind_ff  <= W_CR;
                end else begin
                  // RULE10: byte sent and acknowledged
                  btf_ff   <= 1'b1;
                  tra_ff   <= 1'b1;
                  event_ff <= 1'b1;
                  kind_ff  <= W_TXD;
                end
              end
            end
          end
          // RULE12: misplaced start or stop mid-byte
          if (startPulse || stopPulse) begin
            bus_error_flag_ff     <= 1'b1;
            event_ff    <= 1'b1;
            sclDrive_ff <= 1'b0;
            state_ff    <= ST_HOLD;
          end
        end
        ST_STP1: begin
          if (tick) begin
            sclDrive_ff <= 1'b0;
            state_ff    <= ST_STP2;
          end
        end
        ST_STP2: begin
          if (tick && sclLevel)
            state_ff <= ST_STP3;
        end
        ST_STP3: begin
          if (tick) begin
            sdaDrive_ff <= 1'b0;
            stop_ff     <= 1'b0;
            master_ff   <= 1'b0;
            suppress_ff <= 1'b1;
            state_ff    <= ST_IDLE;
          end
        end
        ST_HOLD: begin
          // RULE15: clock free, data line left as is
          sclDrive_ff <= 1'b0;
          // RULE13: software resumes with stop or start
          if (stop_ff) begin
            sclDrive_ff <= 1'b1;
            sdaDrive_ff <= 1'b1;
            state_ff    <= ST_STP1;
          end else if (start_ff)
            state_ff <= ST_STA0;
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  assign prdata           = prdata_ff;
  assign pready           = 1'b1;
  assign pslverr          = access & ~isMapped(paddr);
  assign sclOut           = 1'b0;
  assign sclOe            = sclDrive_ff;
  assign sdaOut           = 1'b0;
  assign sdaOe            = sdaDrive_ff;
  assign irq              = irq_ff;
  // RULE17: every event may leave wait mode
  assign wakeRequest      = event_ff;
  assign generalCallMatch = gcMatch_ff;
endmodule // i2c_master_event_control

// *** sim/i2c_bus_slave.sv ***
// two-wire slave stub that acknowledges bytes on the open-drain lines
`timescale 1ns/1ps
module i2c_bus_slave (
  input  wire scl,
  input  wire sda,
  input  wire nack,
  output reg  sdaLow
);
  integer bits;
  initial begin
    bits = 0;
    sdaLow = 1'b0;
  end
  // start or repeated start restarts the count
  always @(negedge sda) if (scl) bits = 0;
  // ack slot after eighth bit, refused on request
  always @(negedge scl) begin
    bits = bits + 1;
    sdaLow = (bits == 9) && !nack;
    if (bits == 10) bits = 1;
  end
endmodule // i2c_bus_slave

// *** sim/i2c_master_event_control_assertions.sv ***
// port checker for the bus master
`timescale 1ns/1ps
`include "i2c_defs.vh"
module i2c_master_event_control_checker (
  input wire        clock,
  input wire        reset,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        sclOut,
  input wire        sclOe,
  input wire        sdaOut,
  input wire        sdaOe,
  input wire        irq,
  input wire        wakeRequest,
  input wire        generalCallMatch
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  wire wr  = psel && penable && pwrite;
  wire ctl = wr && paddr == `ADDR_CONTROL;
  property p_ready; psel && penable |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("access not answered");
  property p_hole; psel && penable && paddr == 8'h1C |-> pslverr && prdata == 32'h0; endproperty
  a_hole: assert property (p_hole) else $error("unmapped access not refused");
  property p_drain; sclOut == 1'b0 && sdaOut == 1'b0; endproperty
  a_drain: assert property (p_drain) else $error("line driven high");
  property p_off; ctl && !pwdata[5] |-> ##[1:8] (!sclOe && !sdaOe && !irq && !generalCallMatch);
  endproperty
  a_off: assert property (p_off) else $error("outputs kept after disable");
  property p_start; ctl && pwdata[5] && pwdata[3] |-> ##[1:200] (sdaOe && !sclOe); endproperty
  a_start: assert property (p_start) else $error("no start generated");
  property p_cause; irq |-> wakeRequest || $past(wakeRequest); endproperty
  a_cause: assert property (p_cause) else $error("interrupt without event");
  property p_mask; wr && paddr == `ADDR_IRQ_MASK && !pwdata[0] |=> ##1 !irq; endproperty
  a_mask: assert property (p_mask) else $error("masked interrupt raised");
  property p_ite; ctl && !pwdata[0] |=> ##1 !irq; endproperty
  a_ite: assert property (p_ite) else $error("interrupt with enable off");
  // main flows seen at least once
  c_start: cover property (ctl && pwdata[3]);
  c_irq: cover property ($rose(irq));
  c_hole: cover property (pslverr);
endmodule // i2c_master_event_control_checker
bind i2c_master_event_control i2c_master_event_control_checker chk (.clock(clock),
  .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclOut(sclOut),
  .sclOe(sclOe), .sdaOut(sdaOut), .sdaOe(sdaOe), .irq(irq), .wakeRequest(wakeRequest),
  .generalCallMatch(generalCallMatch));

// *** sim/i2c_master_event_control_test.sv ***
// self-checking bench for the bus master with random bytes
`timescale 1ns/1ps
`include "i2c_defs.vh"
module i2c_master_event_control_test;
  reg         clock = 1'b0;
  reg         reset = 1'b1;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [7:0]  paddr = 8'h00;
  reg  [31:0] pwdata = 32'h0;
  reg         nack = 1'b0;
  reg  [31:0] seed = 32'h62;
  reg  [31:0] rd;
  reg         err;
  integer     n_fail = 0;
  integer     cmp_count = 0;
  integer     i, j, k;
  wire [31:0] prdata;
  wire        pready, pslverr, sclOut, sclOe, sdaOut, sdaOe, irq, wake, sdaLow;
  // open-drain lines with pull-ups
  wire        scl = !sclOe;
  wire        sda = !(sdaOe || sdaLow);
  always #20 clock = !clock;
  i2c_master_event_control dut (.clock(clock), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sclIn(scl), .sclOut(sclOut), .sclOe(sclOe),
    .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe), .irq(irq), .wakeRequest(wake),
    .generalCallMatch());
  i2c_bus_slave peer (.scl(scl), .sda(sda), .nack(nack), .sdaLow(sdaLow));
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  function [31:0] sr1(input ev, input ms, input sb);
    sr1 = {24'h000000, ev, 5'h00, ms, sb};
  endfunction
  task results;
    begin
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task limit(input integer n);
    if (n >= 3000) begin
      n_fail = n_fail + 1;
      $display("BAD %0t wait ran out", $time);
      results;
    end
  endtask
  task apb(input w, input [7:0] a, input [7:0] d);
    begin
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      for (i = 0; pready !== 1'b1 && i < 3000; i = i + 1) @(posedge clock);
      limit(i);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // event flag is registered, let the clearing access land first
  task waitEv;
    begin
      repeat (4) @(posedge clock);
      for (i = 0; wake !== 1'b1 && i < 3000; i = i + 1) @(posedge clock);
      limit(i);
    end
  endtask
  initial begin
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    apb(0, `ADDR_CONTROL, 8'h00);
    chk(rd, 32'h0);
    apb(0, 8'h1C, 8'h00);
    chk({rd[30:0], err}, 32'h1);
    apb(1, `ADDR_CONTROL, 8'h25);
    apb(0, `ADDR_CONTROL, 8'h00);
    chk(rd, 32'h20);
    apb(1, `ADDR_CLOCK_CTRL, 8'h02);
    apb(1, `ADDR_IRQ_MASK, 8'h01);
    apb(1, `ADDR_CONTROL, 8'h25);
    apb(0, `ADDR_CONTROL, 8'h00);
    chk(rd, 32'h25);
    // first pass acknowledged transmit, second a refused address
    for (k = 0; k < 2; k = k + 1) begin
      nack <= k[0];
      apb(1, `ADDR_CONTROL, 8'h2D);
      waitEv;
      apb(0, `ADDR_STATUS_ONE, 8'h00);
      chk(rd & 32'h83, sr1(1, 1, 1));
      chk({31'h0, irq}, 32'h1);
      chk({31'h0, sclOe}, 32'h1);
      apb(0, `ADDR_CONTROL, 8'h00);
      chk(rd, 32'h25);
      seed = xs(seed);
      apb(1, `ADDR_TX_DATA, {1'b0, seed[6:1], 1'b0});
      waitEv;
      if (k == 0) begin
        chk({31'h0, sclOe}, 32'h1);
        apb(0, `ADDR_STATUS_ONE, 8'h00);
        apb(1, `ADDR_CONTROL, 8'h24);
        apb(0, `ADDR_STATUS_ONE, 8'h00);
        seed = xs(seed);
        apb(1, `ADDR_TX_DATA, seed[7:0]);
        waitEv;
        apb(0, `ADDR_STATUS_ONE, 8'h00);
        chk(rd & 32'h2A, 32'h2A);
        chk({30'h0, sclOe, irq}, 32'h2);
        apb(1, `ADDR_TX_DATA, 8'hFF);
      end else begin
        apb(0, `ADDR_STATUS_TWO, 8'h00);
        chk(rd, 32'h10);
        chk({31'h0, sclOe}, 32'h0);
      end
      apb(1, `ADDR_CONTROL, 8'h27);
      rd = 32'h2;
      for (j = 0; rd[1] !== 1'b0 && j < 3000; j = j + 1) apb(0, `ADDR_STATUS_ONE, 8'h00);
      limit(j);
      apb(0, `ADDR_CONTROL, 8'h00);
      chk(rd, 32'h25);
    end
    // 10-bit read: header, second byte, repeated start, read header
    nack <= 1'b0;
    apb(1, `ADDR_CONTROL, 8'h2D);
    waitEv;
    apb(0, `ADDR_STATUS_ONE, 8'h00);
    apb(1, `ADDR_TX_DATA, 8'hF0);
    waitEv;
    apb(0, `ADDR_STATUS_ONE, 8'h00);
    chk(rd & 32'h40, 32'h40);
    apb(1, `ADDR_TX_DATA, seed[7:0]);
    waitEv;
    apb(0, `ADDR_STATUS_ONE, 8'h00);
    // repeated start, header with read bit
    apb(1, `ADDR_CONTROL, 8'h2D);
    waitEv;
    apb(0, `ADDR_STATUS_ONE, 8'h00);
    apb(1, `ADDR_TX_DATA, 8'hF1);
    waitEv;
    apb(0, `ADDR_STATUS_ONE, 8'h00);
    // ack off before the last byte
    apb(1, `ADDR_CONTROL, 8'h21);
    waitEv;
    apb(1, `ADDR_CONTROL, 8'h23);
    apb(0, `ADDR_STATUS_ONE, 8'h00);
    chk(rd & 32'h2A, 32'h0A);
    apb(0, `ADDR_RX_DATA, 8'h00);
    chk(rd, 32'hFF);
    rd = 32'h2;
    for (j = 0; rd[1] !== 1'b0 && j < 3000; j = j + 1) apb(0, `ADDR_STATUS_ONE, 8'h00);
    limit(j);
    apb(1, `ADDR_IRQ_MASK, 8'h00);
    apb(1, `ADDR_CONTROL, 8'h02);
    apb(0, `ADDR_CONTROL, 8'h00);
    chk(rd, 32'h02);
    apb(0, `ADDR_STATUS_ONE, 8'h00);
    chk(rd & 32'hEF, 32'h0);
    results;
  end
endmodule // i2c_master_event_control_test
